// [core/ppfs_pkg.sv]
// Package of constants for the port pin function select block
package ppfs_pkg;
  // Register word indexes; some printed offsets are not word aligned,
  // so each is an index and the byte address is four times it
  localparam logic [7:0] IDX_SER_ONE   = 8'h10;
  localparam logic [7:0] IDX_SER_TWO   = 8'h14;
  localparam logic [7:0] IDX_TMR_ONE   = 8'h18;
  localparam logic [7:0] IDX_TOC_ONE   = 8'h19;
  localparam logic [7:0] IDX_TMR_TWO   = 8'h1c;
  localparam logic [7:0] IDX_TOC_TWO   = 8'h1d;
  localparam logic [7:0] IDX_TOC_THREE = 8'h21;
  localparam logic [7:0] IDX_ANALOG    = 8'h25;
  localparam logic [7:0] IDX_IRQ_PIN   = 8'h27;
  // Own registers: serial settings, direction, stop, status, clear, enable
  localparam logic [7:0] IDX_SER_CTRL  = 8'h30;
  localparam logic [7:0] IDX_DIR       = 8'h31;
  localparam logic [7:0] IDX_STOP      = 8'h32;
  localparam logic [7:0] IDX_STATUS    = 8'h33;
  localparam logic [7:0] IDX_CLEAR     = 8'h34;
  localparam logic [7:0] IDX_ENABLE    = 8'h35;
  localparam int         ADDR_W        = 10;
  localparam logic [3:0] REG_RST       = 4'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Serial pin select fields
  localparam int SEL_CLK  = 2;
  localparam int SEL_IN   = 1;
  localparam int SEL_OUT  = 0;
  // Timer output control fields
  localparam int TOC_IRQ  = 3;
  localparam int TOC_PWM  = 2;
  localparam logic [1:0] TOC_INHIBIT = 2'h0;
  // Serial channel setting: bit 0 clock output mode, bits 2:1 transfer mode
  localparam int SC_CLKOUT = 0;
  localparam logic [1:0] XFER_TX   = 2'h1;
  localparam logic [1:0] XFER_TXRX = 2'h3;
  // Direction register bit for the comparator reference pin
  localparam int DIR_VREF = 0;
endpackage

// [core/ppfs_sync.sv]
`timescale 1ns/1ns
// Two flop synchroniser for a bus of pin inputs
module ppfs_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // Two stages; only dout is visible to logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// [core/ppfs_serial_pins.sv]
`timescale 1ns/1ns
// Direction decode for one serial channel's three pins
module ppfs_serial_pins
  import ppfs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] pin_sel,
  input  wire logic [2:0] setting,
  input  wire logic       stop,
  output logic            tx_enable,
  output logic            clk_oe_n,
  output logic            clk_is_in,
  output logic            out_oe_n
);
  logic tx_d;  // Transmit enable from the transfer mode

  // Transmit or transmit-and-receive modes enable the transmitter
  assign tx_d = (setting[2:1] == XFER_TX) || (setting[2:1] == XFER_TXRX);

  // Registered pin directions; stop floats every driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_enable <= 1'b0;
      clk_oe_n  <= 1'b1;
      clk_is_in <= 1'b0;
      out_oe_n  <= 1'b1;
    end else begin
      tx_enable <= tx_d;
      clk_oe_n  <= stop || !(pin_sel[SEL_CLK] && setting[SC_CLKOUT]);
      clk_is_in <= pin_sel[SEL_CLK] && !setting[SC_CLKOUT];
      out_oe_n  <= stop || !(pin_sel[SEL_OUT] && tx_d);
    end
  end
endmodule

// [core/ppfs_top.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
// Port pin function select: mode registers, pin routing and AXI4-Lite slave
module ppfs_top
  import ppfs_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        ext_irq_pins,
  input  wire logic [3:0]        serial_clk_out,
  output logic [3:0]             irq_sel_q,
  output logic [3:0]             analog_q,
  output logic                   vref_route_q,
  output logic                   vref_dir_q,
  output logic [1:0]             serial_tx_enable,
  output logic [1:0]             serial_clock_oe_n,
  output logic [1:0]             serial_clock_is_input,
  output logic [1:0]             serial_out_oe_n,
  output logic [1:0]             serial_clock_level,
  output logic [2:0]             timer_out_oe_n,
  output logic [1:0]             timer_in_irq_sel_q,
  output logic                   pullup_en_q,
  output logic                   irq_q
);
  // Register storage
  logic [3:0] ser_sel_q [2];   // Serial pin select one and two
  logic [3:0] tmr_mode_q [2];  // Timer mode one and two
  logic [3:0] toc_q [3];       // Timer output control one to three
  logic [5:0] ser_ctrl_q;      // Serial settings, three bits per channel
  logic       dir_q;           // Direction of the reference capable pin
  logic       stop_q;          // Stop mode request
  logic [3:0] flag_q;          // Interrupt flags, sticky
  logic [3:0] irq_en_q;        // Interrupt enables
  logic [3:0] pins_s;          // Synchronised interrupt pins
  logic [3:0] pin_act;         // Pin level at its active polarity
  logic [3:0] flag_set;        // Flag set events this cycle
  logic [3:0] pin_act_q;       // Previous active level, for edges
  // Write channel state
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic              wr_fire;
  logic [7:0]        wr_idx;
  logic [3:0]        wd;
  logic              wr_hit;
  logic              rd_hit;
  logic [3:0]        rd_val;

  // Word index from a byte address
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction

  // Is this index a mapped register
  function automatic logic mapped(input logic [7:0] i);
    if (i == IDX_SER_ONE || i == IDX_SER_TWO || i == IDX_TMR_ONE) mapped = 1'b1;
    else if (i == IDX_TOC_ONE || i == IDX_TMR_TWO || i == IDX_TOC_TWO) mapped = 1'b1;
    else if (i == IDX_TOC_THREE || i == IDX_ANALOG || i == IDX_IRQ_PIN) mapped = 1'b1;
    else if (i == IDX_SER_CTRL || i == IDX_DIR || i == IDX_STOP) mapped = 1'b1;
    else if (i == IDX_STATUS || i == IDX_CLEAR || i == IDX_ENABLE) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction

  // Interrupt pins cross from outside before any logic reads them
  ppfs_sync #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (ext_irq_pins),
    .dout    (pins_s)
  );

  // Pins zero and one are active low, two and three active high
  assign pin_act = {pins_s[3], pins_s[2], ~pins_s[1], ~pins_s[0]};

  // Write commits once both address and data are held
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_idx  = word_idx(aw_addr_q);
  assign wd      = w_data_q[3:0];
  assign wr_hit  = mapped(wr_idx);

  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready;
      s_axi_wready  <= !w_have_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Mode registers; the low nibble of the data carries the value, six bits for the serial settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sel_q  <= REG_RST;
      analog_q   <= REG_RST;
      ser_sel_q  <= '{default: REG_RST};
      tmr_mode_q <= '{default: REG_RST};
      toc_q      <= '{default: REG_RST};
      ser_ctrl_q <= '0;
      stop_q     <= 1'b0;
    end else if (wr_fire) begin
      if (wr_idx == IDX_IRQ_PIN) irq_sel_q <= wd;
      else if (wr_idx == IDX_ANALOG) analog_q <= wd;
      else if (wr_idx == IDX_SER_ONE) ser_sel_q[0] <= wd;
      else if (wr_idx == IDX_SER_TWO) ser_sel_q[1] <= wd;
      else if (wr_idx == IDX_TMR_ONE) tmr_mode_q[0] <= wd;
      else if (wr_idx == IDX_TMR_TWO) tmr_mode_q[1] <= wd;
      else if (wr_idx == IDX_TOC_ONE) toc_q[0] <= wd;
      else if (wr_idx == IDX_TOC_TWO) toc_q[1] <= wd;
      else if (wr_idx == IDX_TOC_THREE) toc_q[2] <= wd;
      else if (wr_idx == IDX_SER_CTRL) ser_ctrl_q <= w_data_q[5:0];
      else if (wr_idx == IDX_STOP) stop_q <= w_data_q[0];
    end
  end

  // Direction bit; analog mode forces it clear, which beats a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 1'b0;
    end else if (analog_q != REG_RST) begin
      dir_q <= 1'b0;
    end else if (wr_fire && wr_idx == IDX_DIR) begin
      dir_q <= w_data_q[DIR_VREF];
    end
  end

  // Flag set: a newly enabled pin already at its active level sets at
  // once; an enabled pin sets on a fresh active transition afterwards
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      flag_set[i] = irq_sel_q[i] && pin_act[i] && !pin_act_q[i];
      if (wr_fire && wr_idx == IDX_IRQ_PIN && wd[i] && !irq_sel_q[i] && pin_act[i]) begin
        flag_set[i] = 1'b1;
      end
    end
  end

  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q    <= REG_RST;
      pin_act_q <= REG_RST;
      irq_en_q  <= REG_RST;
    end else begin
      pin_act_q <= pin_act;
      if (wr_fire && wr_idx == IDX_CLEAR) flag_q <= (flag_q & ~wd) | flag_set;
      else flag_q <= flag_q | flag_set;
      if (wr_fire && wr_idx == IDX_ENABLE) irq_en_q <= wd;
    end
  end

  // Interrupt level output
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_q <= 1'b0;
    else irq_q <= |(flag_q & irq_en_q);
  end

  // Read data decode; write-only registers read as zero
  always_comb begin
    rd_val = 4'h0;
    if (word_idx(s_axi_araddr) == IDX_SER_ONE) rd_val = ser_sel_q[0];
    else if (word_idx(s_axi_araddr) == IDX_SER_TWO) rd_val = ser_sel_q[1];
    else if (word_idx(s_axi_araddr) == IDX_TOC_ONE) rd_val = toc_q[0];
    else if (word_idx(s_axi_araddr) == IDX_TOC_TWO) rd_val = toc_q[1];
    else if (word_idx(s_axi_araddr) == IDX_TOC_THREE) rd_val = toc_q[2];
    else if (word_idx(s_axi_araddr) == IDX_STATUS) rd_val = flag_q;
    else if (word_idx(s_axi_araddr) == IDX_ENABLE) rd_val = irq_en_q;
    else if (word_idx(s_axi_araddr) == IDX_DIR) rd_val = {3'h0, dir_q};
    else if (word_idx(s_axi_araddr) == IDX_STOP) rd_val = {3'h0, stop_q};
  end
  assign rd_hit = mapped(word_idx(s_axi_araddr));

  // Read channel: arready held high when idle, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {28'h0000000, rd_val};
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Serial channels, one decoder each
  for (genvar c = 0; c < 2; c++) begin : g_ser
    ppfs_serial_pins u_ser (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_sel   (ser_sel_q[c]),
      .setting   (ser_ctrl_q[3*c +: 3]),
      .stop      (stop_q),
      .tx_enable (serial_tx_enable[c]),
      .clk_oe_n  (serial_clock_oe_n[c]),
      .clk_is_in (serial_clock_is_input[c]),
      .out_oe_n  (serial_out_oe_n[c])
    );
  end

  // Clock pin level follows the internal transfer clock one edge late;
  // it only reaches the pin while the clock pin drives, so direction never toggles
  always_ff @(posedge aclk) begin
    if (!aresetn) serial_clock_level <= 2'h0;
    else serial_clock_level <= serial_clk_out[1:0];
  end

  // Any non-inhibit mode drives the pin outside stop; the PWM bit alone does not, so code 4 floats
  for (genvar t = 0; t < 3; t++) begin : g_tmr
    always_ff @(posedge aclk) begin
      if (!aresetn) timer_out_oe_n[t] <= 1'b1;
      else timer_out_oe_n[t] <= stop_q || (toc_q[t][1:0] == TOC_INHIBIT);
    end
  end

  // Timer input pins switch to interrupt use on control bit three
  always_ff @(posedge aclk) begin
    if (!aresetn) timer_in_irq_sel_q <= 2'h0;
    else timer_in_irq_sel_q <= {toc_q[1][TOC_IRQ], toc_q[0][TOC_IRQ]};
  end

  // Reference routing and direction; stop floats and drops pull-ups
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vref_route_q <= 1'b0;
      vref_dir_q   <= 1'b0;
      pullup_en_q  <= 1'b1;
    end else begin
      vref_route_q <= analog_q != REG_RST;
      vref_dir_q   <= dir_q && !stop_q;
      pullup_en_q  <= !stop_q;
    end
  end

  // A flag must be set the cycle after enabling an active pin
  AST_ENABLE_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_idx == IDX_IRQ_PIN && wd[0] && !irq_sel_q[0] && pin_act[0])
    |=> flag_q[0])
    else $error("enable of active low pin did not set flag");
  AST_HIGH_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_idx == IDX_IRQ_PIN && wd[2] && !irq_sel_q[2] && pin_act[2])
    |=> flag_q[2])
    else $error("enable of active high pin did not set flag");
  AST_STOP_FLOAT: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_q |=> (&timer_out_oe_n) && (&serial_out_oe_n) && !pullup_en_q)
    else $error("pins not floated in stop mode");
  AST_VREF_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    (analog_q != REG_RST) |=> !dir_q)
    else $error("reference pin direction not cleared");
  AST_TIMER_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (!stop_q && toc_q[0][1:0] != TOC_INHIBIT) |=> !timer_out_oe_n[0])
    else $error("timer pin not driven");
  AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(|(flag_q & irq_en_q)) |=> irq_q)
    else $error("interrupt output late");
  AST_TI_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    toc_q[1][TOC_IRQ] |=> timer_in_irq_sel_q[1])
    else $error("timer input interrupt select wrong");
  AST_WR_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  // Serial pin directions follow the channel settings one edge later
  AST_CLK_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!stop_q && ser_sel_q[0][SEL_CLK] && ser_ctrl_q[SC_CLKOUT]) |=> !serial_clock_oe_n[0])
    else $error("clock pin not driven in clock output mode");
  AST_TX_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (!stop_q && ser_sel_q[1][SEL_OUT] && ser_ctrl_q[5:4] == XFER_TXRX)
    |=> (!serial_out_oe_n[1] && serial_tx_enable[1]))
    else $error("serial out pin not driven in transmit mode");
  AST_PULLUP_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
    !stop_q |=> pullup_en_q)
    else $error("pull-ups off outside stop mode");
endmodule

// [test/ppfs_pin_model.sv]
`timescale 1ns/1ns
// Model of the external pins: interrupt pin levels and transfer clock sources
module ppfs_pin_model (
  input  wire logic       aclk,
  input  wire logic [3:0] level,
  input  wire logic [3:0] clk_run,
  output logic      [3:0] ext_irq_pins,
  output logic      [3:0] serial_clk_out = 4'h0
);
  // Pin levels follow the bench's command; no pulls, so no hidden default
  assign ext_irq_pins = level;

  // A transfer clock toggles only while its channel runs, else stands low
  always_ff @(posedge aclk) begin
    serial_clk_out <= (serial_clk_out ^ clk_run) & clk_run;
  end
endmodule

// [test/ppfs_top_tb_top.sv]
`timescale 1ns/1ns
// Self-checking testbench for the port pin function select block
module ppfs_top_tb_top
  import ppfs_pkg::*;
();
  logic              aclk    = 1'b0;   // System clock
  logic              aresetn = 1'b0;   // Reset, active low
  logic [ADDR_W-1:0] awaddr  = 10'h000, araddr = 10'h000;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic [31:0]       wdata   = 32'h0;
  logic [3:0]        pin_level = 4'h3;  // All four pins start inactive
  logic [3:0]        clk_run = 4'h0;    // Transfer clocks stand still
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [3:0]        ext_irq_pins, serial_clk_out, irq_sel_q, analog_q;
  logic              vref_route_q, vref_dir_q, pullup_en_q, irq_q, lvl_seen;
  logic [1:0]        tx_en, clk_oe_n, clk_in, out_oe_n, tin_irq, clk_lvl;
  logic [2:0]        tmr_oe_n;
  int                fails = 0, checks_done = 0;
  logic [5:0]        toc_drv = 6'b101110; // Codes 1 to 3 and 5 drive, 0 and 4 do not

  // Half period of 2 ns gives 250 MHz
  always #2 aclk = ~aclk;

  ppfs_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_irq_pins(ext_irq_pins),
    .serial_clk_out(serial_clk_out), .irq_sel_q(irq_sel_q), .analog_q(analog_q),
    .vref_route_q(vref_route_q), .vref_dir_q(vref_dir_q), .serial_tx_enable(tx_en),
    .serial_clock_oe_n(clk_oe_n), .serial_clock_is_input(clk_in),
    .serial_out_oe_n(out_oe_n), .serial_clock_level(clk_lvl), .timer_out_oe_n(tmr_oe_n),
    .timer_in_irq_sel_q(tin_irq), .pullup_en_q(pullup_en_q), .irq_q(irq_q));

  ppfs_pin_model pins (.aclk(aclk), .level(pin_level), .clk_run(clk_run),
    .ext_irq_pins(ext_irq_pins), .serial_clk_out(serial_clk_out));

  // Case equality so an unknown never passes
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write one word; readies are sampled mid-cycle since they move on edges
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic a_ok, w_ok, b_ok, ra, rw, rb;
    logic [1:0] r;
    a_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      rb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (!a_ok && ra === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && rw === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (rb === 1'b1) begin
        b_ok = 1'b1;
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
      end
    end
  endtask

  // Read one word and compare data and response
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    logic a_ok, rv;
    logic [31:0] d;
    logic [1:0] r;
    a_ok = 1'b0;
    rv = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv) begin
      @(negedge aclk);
      if (!a_ok && arready === 1'b1) a_ok = 1'b1;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // Pin outputs follow a register one edge later; allow margin
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("irq_sel", 32'h0, {28'h0, irq_sel_q});
    chk("analog", 32'h0, {28'h0, analog_q});
    chk("timer_oe_n", 32'h7, {29'h0, tmr_oe_n});
    chk("pullup", 32'h1, {31'h0, pullup_en_q});
    rd(IDX_SER_ONE, 32'h0, RESP_OKAY);
    rd(IDX_IRQ_PIN, 32'h0, RESP_OKAY);
    $display("test reset done");
    // Inactive levels: enabling the pins must set no flag
    wr(IDX_ENABLE, 32'hf, RESP_OKAY);
    wr(IDX_IRQ_PIN, 32'hf, RESP_OKAY);
    settle();
    chk("irq_sel", 32'hf, {28'h0, irq_sel_q});
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_PIN, 32'h0, RESP_OKAY);
    pin_level <= 4'h6; // Pins 0 and 2 active, 1 and 3 not
    settle();
    wr(IDX_IRQ_PIN, 32'hf, RESP_OKAY);
    settle();
    rd(IDX_STATUS, 32'h5, RESP_OKAY);
    chk("irq", 32'h1, {31'h0, irq_q});
    wr(IDX_CLEAR, 32'hf, RESP_OKAY);
    wr(IDX_ENABLE, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_PIN, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_PIN, 32'h3, RESP_OKAY);
    settle();
    rd(IDX_STATUS, 32'h1, RESP_OKAY);
    chk("irq_masked", 32'h0, {31'h0, irq_q});
    wr(IDX_ENABLE, 32'h1, RESP_OKAY);
    settle();
    chk("irq", 32'h1, {31'h0, irq_q});
    wr(IDX_CLEAR, 32'h1, RESP_OKAY);
    settle();
    chk("irq_cleared", 32'h0, {31'h0, irq_q});
    $display("test interrupt pins done");
    wr(IDX_DIR, 32'h1, RESP_OKAY);
    settle();
    chk("vref_dir", 32'h1, {31'h0, vref_dir_q});
    wr(IDX_ANALOG, 32'h8, RESP_OKAY);
    settle();
    chk("analog", 32'h8, {28'h0, analog_q});
    chk("vref_route", 32'h1, {31'h0, vref_route_q});
    chk("vref_dir", 32'h0, {31'h0, vref_dir_q});
    rd(IDX_ANALOG, 32'h0, RESP_OKAY);
    wr(IDX_DIR, 32'h1, RESP_OKAY);
    settle();
    chk("vref_dir_forced", 32'h0, {31'h0, vref_dir_q});
    wr(IDX_ANALOG, 32'h0, RESP_OKAY);
    settle();
    chk("vref_route", 32'h0, {31'h0, vref_route_q});
    wr(IDX_DIR, 32'h1, RESP_OKAY);
    $display("test analog done");
    // Channel 0: clock out, transmit; channel 1: clock in, transmit and receive
    clk_run <= 4'h1;
    wr(IDX_SER_ONE, 32'h7, RESP_OKAY);
    wr(IDX_SER_TWO, 32'h7, RESP_OKAY);
    wr(IDX_SER_CTRL, 32'h33, RESP_OKAY);
    settle();
    chk("tx_en", 32'h3, {30'h0, tx_en});
    chk("clk_oe_n", 32'h2, {30'h0, clk_oe_n});
    chk("clk_in", 32'h2, {30'h0, clk_in});
    chk("out_oe_n", 32'h0, {30'h0, out_oe_n});
    // The clock pin level runs with the transfer clock: it flips every cycle
    @(negedge aclk);
    lvl_seen = clk_lvl[0];
    @(negedge aclk);
    chk("clk_pin_toggle", 32'h1, {31'h0, lvl_seen ^ clk_lvl[0]});
    rd(IDX_SER_TWO, 32'h7, RESP_OKAY);
    wr(IDX_SER_CTRL, 32'h35, RESP_OKAY);
    settle();
    chk("tx_en_rx", 32'h2, {30'h0, tx_en});
    chk("out_oe_n_rx", 32'h1, {30'h0, out_oe_n});
    wr(IDX_SER_ONE, 32'h0, RESP_OKAY);
    settle();
    chk("clk_oe_n_port", 32'h3, {30'h0, clk_oe_n});
    wr(IDX_SER_ONE, 32'h7, RESP_OKAY);
    wr(IDX_SER_CTRL, 32'h33, RESP_OKAY);
    clk_run <= 4'h0;
    $display("test serial done");
    for (int i = 0; i < 6; i++) begin
      wr(IDX_TOC_ONE, i, RESP_OKAY);
      wr(IDX_TOC_THREE, i, RESP_OKAY);
      settle();
      chk("timer_oe_n", {29'h0, !toc_drv[i], 1'b1, !toc_drv[i]}, {29'h0, tmr_oe_n});
      rd(IDX_TOC_ONE, i, RESP_OKAY);
    end
    wr(IDX_TOC_TWO, 32'h8, RESP_OKAY);
    settle();
    chk("timer_in_irq", 32'h2, {30'h0, tin_irq});
    rd(IDX_TOC_TWO, 32'h8, RESP_OKAY);
    wr(IDX_TOC_ONE, 32'hffff_fff1, RESP_OKAY);
    rd(IDX_TOC_ONE, 32'h1, RESP_OKAY);
    wr(IDX_TMR_ONE, 32'h5, RESP_OKAY);
    rd(IDX_TMR_ONE, 32'h0, RESP_OKAY);
    rd(IDX_TMR_TWO, 32'h0, RESP_OKAY);
    $display("test timer done");
    wr(IDX_STOP, 32'h1, RESP_OKAY);
    settle();
    chk("stop_clk_oe_n", 32'h3, {30'h0, clk_oe_n});
    chk("stop_out_oe_n", 32'h3, {30'h0, out_oe_n});
    chk("stop_timer_oe_n", 32'h7, {29'h0, tmr_oe_n});
    chk("stop_pullup", 32'h0, {31'h0, pullup_en_q});
    chk("stop_vref_dir", 32'h0, {31'h0, vref_dir_q});
    wr(IDX_STOP, 32'h0, RESP_OKAY);
    settle();
    chk("run_pullup", 32'h1, {31'h0, pullup_en_q});
    chk("run_timer_oe_n", 32'h2, {29'h0, tmr_oe_n});
    $display("test stop done");
    wr(8'h3f, 32'h1, RESP_SLVERR);
    rd(8'h3f, 32'h0, RESP_SLVERR);
    $display("test unmapped done");
    complete_run();
  end
endmodule
